// ===== common/rtcap_regs.svh
`ifndef RTCAP_REGS_SVH
`define RTCAP_REGS_SVH
// Register byte offsets
`define RTCAP_OFS_WDHR     8'h00
`define RTCAP_OFS_MINSEC   8'h04
`define RTCAP_OFS_PWT      8'h08
`define RTCAP_OFS_ALCFG    8'h0C
`define RTCAP_OFS_CAL      8'h10
`define RTCAP_OFS_WIN      8'h14
// Alarm configuration fields
`define RTCAP_ALCFG_EN     15
`define RTCAP_ALCFG_CHIME  14
`define RTCAP_ALCFG_MSK_H  13
`define RTCAP_ALCFG_MSK_L  10
`define RTCAP_ALCFG_PTR_H  9
`define RTCAP_ALCFG_PTR_L  8
// Calibration and control fields
`define RTCAP_CAL_POWER_CTRL_ENABLE    15
`define RTCAP_CAL_UNLOCK   13
`define RTCAP_CAL_SYNC     12
// Interval mask codes
`define RTCAP_MSK_HALF     4'h0
`define RTCAP_MSK_SEC      4'h1
`define RTCAP_MSK_10SEC    4'h2
`define RTCAP_MSK_MIN      4'h3
`define RTCAP_MSK_10MIN    4'h4
`define RTCAP_MSK_HOUR     4'h5
`define RTCAP_MSK_DAY      4'h6
`define RTCAP_MSK_WEEK     4'h7
`define RTCAP_MSK_MONTH    4'h8
`define RTCAP_MSK_YEAR     4'h9
// Special counts and reset values
`define RTCAP_SAMP_ALWAYS  8'hFF
`define RTCAP_RPT_ROLL     8'hFF
`define RTCAP_RST_BYTE     8'h00
`endif

// ===== common/rtcap_pkg.sv
package rtcap_pkg;
  // Current clock digits, BCD, from the time counter
  typedef struct packed {
    logic [2:0] weekday;
    logic [1:0] hour_t;
    logic [3:0] hour_o;
    logic [2:0] min_t;
    logic [3:0] min_o;
    logic [2:0] sec_t;
    logic [3:0] sec_o;
    logic       mday_first; // Day of month is the first
    logic       mon_first;  // Month is the first of the year
  } rtcap_time_t;
  // Timebase strobes, one cycle each, plus the timer_on level
  typedef struct packed {
    logic half_sec; // Every half second
    logic sec;      // Whole-second increment
    logic pwc;      // One power-control clock period elapsed
    logic timer_on; // Timer running
  } rtcap_tick_t;
  // Prescaler correction toward the time counter
  typedef struct packed {
    logic       valid;
    logic [7:0] delta; // Signed pulse count to add
  } rtcap_cal_t;
  // Decoded register selector
  typedef enum logic [2:0] {
    RTCAP_R_WDHR   = 3'b000,
    RTCAP_R_MINSEC = 3'b001,
    RTCAP_R_PWT    = 3'b010,
    RTCAP_R_ALCFG  = 3'b011,
    RTCAP_R_CAL    = 3'b100,
    RTCAP_R_WIN    = 3'b101,
    RTCAP_R_NONE   = 3'b111
  } rtcap_reg_t;
  // Power window sequencer
  typedef enum logic [1:0] {
    RTCAP_S_IDLE = 2'b00,
    RTCAP_S_STAB = 2'b01,
    RTCAP_S_SAMP = 2'b10
  } rtcap_pwc_t;
endpackage

// ===== src/rtcap_top.sv
`timescale 1ns/1ps
`include "rtcap_regs.svh"
// Overview of operation
// - Weekday digit sits in bits 10-8
// - Hour tens bits 5-4, ones 3-0
// - Minute tens bits 14-12, ones 11-8
// - Second tens bits 6-4, ones 3-0
// - Unused alarm bits ignore writes, read zero
// - Weekday/hour and window writes need unlock
// - Stability count sets window; zero skips it
// - Sample count 1-254 periods; zero disables
// - Sample count FFh keeps window always on
// - Sample starts when stability timer expires
// - Four times signed calibration per minute
// - Negative value removes pulses, positive adds
// - Adjust applied every 15 seconds
// - Final alarm clears enable by hardware
// - Interval mask picks digits to compare
// - Repeat zero without chime: single alarm
// - Repeat decrements; at zero last alarm
// - Chime rolls repeat count over to FFh
// - Every alarm raises interrupt request
// - Alarm pulse toggles at half rate
// - Mask codes map; reserved codes never fire
// - Window pointer decrements per window access
module rtcap_top #(
  parameter int AW = 8 // Decoded address bits
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  rtcap_pkg::rtcap_time_t    cur_time,
  input  rtcap_pkg::rtcap_tick_t    ticks,
  input  wire logic                 clock_sync_flag,
  output logic                      alarm_irq,
  output logic                      alarm_pulse,
  output logic                      pwc_power_on,
  output logic                      pwc_sample_win,
  output rtcap_pkg::rtcap_cal_t     cal_adjust
);

  // Decoder needs the offsets up to 0x14 to be distinct
  if (AW < 6 || AW > 32) begin : g_bad_aw
    $error("rtcap_top: AW must lie in 6..32");
  end

  // Map a byte address to a register selector
  function automatic rtcap_pkg::rtcap_reg_t decode(input logic [AW-1:0] a);
    logic [7:0] lo;
    lo = 8'(a);
    if (a[AW-1:5] != '0) return rtcap_pkg::RTCAP_R_NONE;
    unique case (lo)
      `RTCAP_OFS_WDHR:   return rtcap_pkg::RTCAP_R_WDHR;
      `RTCAP_OFS_MINSEC: return rtcap_pkg::RTCAP_R_MINSEC;
      `RTCAP_OFS_PWT:    return rtcap_pkg::RTCAP_R_PWT;
      `RTCAP_OFS_ALCFG:  return rtcap_pkg::RTCAP_R_ALCFG;
      `RTCAP_OFS_CAL:    return rtcap_pkg::RTCAP_R_CAL;
      `RTCAP_OFS_WIN:    return rtcap_pkg::RTCAP_R_WIN;
      default:           return rtcap_pkg::RTCAP_R_NONE;
    endcase
  endfunction

  // Resolve the window alias through the pointer
  function automatic rtcap_pkg::rtcap_reg_t resolve(input rtcap_pkg::rtcap_reg_t r,
                                                    input logic [1:0] p);
    if (r != rtcap_pkg::RTCAP_R_WIN) return r;
    unique case (p)
      2'h0:    return rtcap_pkg::RTCAP_R_MINSEC;
      2'h1:    return rtcap_pkg::RTCAP_R_WDHR;
      2'h3:    return rtcap_pkg::RTCAP_R_PWT;
      default: return rtcap_pkg::RTCAP_R_NONE; // Month/day pair not held here
    endcase
  endfunction

  // Bus tracking
  logic                  wr_pend_q;  // Write data phase in progress
  logic                  rd_wait_q;  // Read wait cycle in progress
  logic [AW-1:0]         wr_addr_q;  // Latched write address
  logic [AW-1:0]         rd_addr_q;  // Latched read address
  logic [31:0]           hrdata_q;   // Read data register
  // Alarm value fields
  logic [2:0]            al_alarm_weekday_digit_q;
  logic [1:0]            al_hr_t_q;
  logic [3:0]            al_hr_o_q;
  logic [2:0]            al_min_t_q;
  logic [3:0]            al_min_o_q;
  logic [2:0]            al_sec_t_q;
  logic [3:0]            al_sec_o_q;
  // Power window counts
  logic [7:0]            stab_q;
  logic [7:0]            samp_q;
  // Alarm configuration
  logic                  al_en_q;
  logic                  chime_q;
  logic [3:0]            mask_q;
  logic [1:0]            ptr_q;
  logic [7:0]            rpt_q;
  // Calibration and control
  logic                  pwc_en_q;
  logic                  unlock_q;
  logic [7:0]            cal_q;
  // Alarm and power window state
  logic                  irq_q;
  logic                  pulse_q;
  rtcap_pkg::rtcap_pwc_t pwc_q;
  logic [7:0]            cnt_q;
  rtcap_pkg::rtcap_cal_t cal_out_q;
  // Combinational helpers
  logic                  take;       // Address phase accepted
  logic                  wr_en;      // Write committed this cycle
  rtcap_pkg::rtcap_reg_t wsel;       // Target of the write
  rtcap_pkg::rtcap_reg_t rsel;       // Source of the read
  logic                  win_acc;    // Window register touched
  logic                  alcfg_wr;   // Software writes configuration
  logic                  hit;        // Mask condition met now
  logic                  alarm_evt;  // Alarm issued this cycle
  logic                  quarter;    // Seconds at 00, 15, 30 or 45
  logic [31:0]           rd_mux;     // Read value before the register

  // Zero-wait writes, one wait state on reads so data comes from a flop
  assign take      = ce & hsel & hready & htrans[1];
  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_en     = ce & wr_pend_q;
  assign wsel      = resolve(decode(wr_addr_q), ptr_q);
  assign rsel      = resolve(decode(rd_addr_q), ptr_q);
  assign alcfg_wr  = wr_en & (wsel == rtcap_pkg::RTCAP_R_ALCFG);
  assign win_acc   = ce & ((wr_pend_q & decode(wr_addr_q) == rtcap_pkg::RTCAP_R_WIN) |
                           (rd_wait_q & decode(rd_addr_q) == rtcap_pkg::RTCAP_R_WIN));

  // Address phase capture; hsize is unused since only words are served
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      wr_addr_q <= '0;
      rd_addr_q <= '0;
    end else if (ce) begin
      wr_pend_q <= take & hwrite;
      rd_wait_q <= take & ~hwrite;
      if (take && hwrite) begin
        wr_addr_q <= haddr[AW-1:0];
      end
      if (take && !hwrite) begin
        rd_addr_q <= haddr[AW-1:0];
      end
    end
  end

  // Read multiplexer; unused bits return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rsel)
      rtcap_pkg::RTCAP_R_WDHR: begin
        rd_mux[10:8] = al_alarm_weekday_digit_q;
        rd_mux[5:4]  = al_hr_t_q;
        rd_mux[3:0]  = al_hr_o_q;
      end
      rtcap_pkg::RTCAP_R_MINSEC: begin
        rd_mux[14:12] = al_min_t_q;
        rd_mux[11:8]  = al_min_o_q;
        rd_mux[6:4]   = al_sec_t_q;
        rd_mux[3:0]   = al_sec_o_q;
      end
      rtcap_pkg::RTCAP_R_PWT: begin
        rd_mux[15:8] = stab_q;
        rd_mux[7:0]  = samp_q;
      end
      rtcap_pkg::RTCAP_R_ALCFG: begin
        rd_mux[`RTCAP_ALCFG_EN]                         = al_en_q;
        rd_mux[`RTCAP_ALCFG_CHIME]                      = chime_q;
        rd_mux[`RTCAP_ALCFG_MSK_H:`RTCAP_ALCFG_MSK_L]   = mask_q;
        rd_mux[`RTCAP_ALCFG_PTR_H:`RTCAP_ALCFG_PTR_L]   = ptr_q;
        rd_mux[7:0]                                     = rpt_q;
      end
      rtcap_pkg::RTCAP_R_CAL: begin
        rd_mux[`RTCAP_CAL_POWER_CTRL_ENABLE]  = pwc_en_q;
        rd_mux[`RTCAP_CAL_UNLOCK] = unlock_q;
        rd_mux[`RTCAP_CAL_SYNC]   = clock_sync_flag; // Live status
        rd_mux[7:0]               = cal_q;
      end
      default: rd_mux = 32'h0000_0000; // Unmapped
    endcase
  end

  // Read data register, loaded in the wait cycle after the write has landed
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && rd_wait_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // Weekday/hour value, locked unless the unlock bit is set
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      al_alarm_weekday_digit_q <= 3'h0;
      al_hr_t_q <= 2'h0;
      al_hr_o_q <= 4'h0;
    end else if (wr_en && wsel == rtcap_pkg::RTCAP_R_WDHR && unlock_q) begin
      al_alarm_weekday_digit_q <= hwdata[10:8];
      al_hr_t_q <= hwdata[5:4];
      al_hr_o_q <= hwdata[3:0];
    end
  end

  // Minute/second value, always writable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      al_min_t_q <= 3'h0;
      al_min_o_q <= 4'h0;
      al_sec_t_q <= 3'h0;
      al_sec_o_q <= 4'h0;
    end else if (wr_en && wsel == rtcap_pkg::RTCAP_R_MINSEC) begin
      al_min_t_q <= hwdata[14:12];
      al_min_o_q <= hwdata[11:8];
      al_sec_t_q <= hwdata[6:4];
      al_sec_o_q <= hwdata[3:0];
    end
  end

  // Power window counts, locked unless the unlock bit is set
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stab_q <= `RTCAP_RST_BYTE;
      samp_q <= `RTCAP_RST_BYTE;
    end else if (wr_en && wsel == rtcap_pkg::RTCAP_R_PWT && unlock_q) begin
      stab_q <= hwdata[15:8];
      samp_q <= hwdata[7:0];
    end
  end

  // Calibration and control register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwc_en_q <= 1'b0;
      unlock_q <= 1'b0;
      cal_q    <= `RTCAP_RST_BYTE;
    end else if (wr_en && wsel == rtcap_pkg::RTCAP_R_CAL) begin
      pwc_en_q <= hwdata[`RTCAP_CAL_POWER_CTRL_ENABLE];
      unlock_q <= hwdata[`RTCAP_CAL_UNLOCK];
      cal_q    <= hwdata[7:0];
    end
  end

  // Mask decode: which digits must equal the clock
  always_comb begin
    logic s_o;
    logic s_t;
    logic m_o;
    logic m_t;
    logic h_m;
    logic w_m;
    s_o = ticks.sec & (cur_time.sec_o == al_sec_o_q);
    s_t = s_o & (cur_time.sec_t == al_sec_t_q);
    m_o = s_t & (cur_time.min_o == al_min_o_q);
    m_t = m_o & (cur_time.min_t == al_min_t_q);
    h_m = m_t & (cur_time.hour_o == al_hr_o_q) & (cur_time.hour_t == al_hr_t_q);
    w_m = h_m & (cur_time.weekday == al_alarm_weekday_digit_q);
    unique case (mask_q)
      `RTCAP_MSK_HALF:  hit = ticks.half_sec;
      `RTCAP_MSK_SEC:   hit = ticks.sec;
      `RTCAP_MSK_10SEC: hit = s_o;
      `RTCAP_MSK_MIN:   hit = s_t;
      `RTCAP_MSK_10MIN: hit = m_o;
      `RTCAP_MSK_HOUR:  hit = m_t;
      `RTCAP_MSK_DAY:   hit = h_m;
      `RTCAP_MSK_WEEK:  hit = w_m;
      `RTCAP_MSK_MONTH: hit = h_m & cur_time.mday_first;
      `RTCAP_MSK_YEAR:  hit = h_m & cur_time.mday_first & cur_time.mon_first;
      default:          hit = 1'b0; // Reserved codes never fire
    endcase
  end

  assign alarm_evt = ce & al_en_q & hit;

  // Alarm configuration; a software write beats the hardware update
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      al_en_q <= 1'b0;
      chime_q <= 1'b0;
      mask_q  <= `RTCAP_MSK_HALF;
      rpt_q   <= `RTCAP_RST_BYTE;
    end else if (alcfg_wr) begin
      al_en_q <= hwdata[`RTCAP_ALCFG_EN];
      chime_q <= hwdata[`RTCAP_ALCFG_CHIME];
      mask_q  <= hwdata[`RTCAP_ALCFG_MSK_H:`RTCAP_ALCFG_MSK_L];
      rpt_q   <= hwdata[7:0];
    end else if (alarm_evt) begin
      if (rpt_q != 8'h00) begin
        rpt_q <= 8'(rpt_q - 8'h01);
      end else if (chime_q) begin
        rpt_q <= `RTCAP_RPT_ROLL;
      end else begin
        al_en_q <= 1'b0;
      end
    end
  end

  // Window pointer: counts down on each window access, stops at zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ptr_q <= 2'h0;
    end else if (alcfg_wr) begin
      ptr_q <= hwdata[`RTCAP_ALCFG_PTR_H:`RTCAP_ALCFG_PTR_L];
    end else if (win_acc && ptr_q != 2'h0) begin
      ptr_q <= 2'(ptr_q - 2'h1);
    end
  end

  // Interrupt request pulse and half-rate alarm output
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      irq_q <= alarm_evt;
      if (alarm_evt) begin
        pulse_q <= ~pulse_q;
      end
    end
  end

  assign alarm_irq   = irq_q;
  assign alarm_pulse = pulse_q;

  // Calibration: one quarter of four times the value at each quarter minute,
  // so the minute total is four times the value with no extra second
  assign quarter = ce & ticks.sec & ticks.timer_on &
                   (({cur_time.sec_t, cur_time.sec_o} == 7'h00) |
                    ({cur_time.sec_t, cur_time.sec_o} == 7'h15) |
                    ({cur_time.sec_t, cur_time.sec_o} == 7'h30) |
                    ({cur_time.sec_t, cur_time.sec_o} == 7'h45));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cal_out_q <= '0;
    end else if (ce) begin
      cal_out_q.valid <= quarter;
      if (quarter) begin
        cal_out_q.delta <= cal_q;
      end
    end
  end

  assign cal_adjust = cal_out_q;

  // Power window sequencer; alarms while busy do not retrigger
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwc_q <= rtcap_pkg::RTCAP_S_IDLE;
      cnt_q <= 8'h00;
    end else if (ce) begin
      if (!pwc_en_q) begin
        pwc_q <= rtcap_pkg::RTCAP_S_IDLE;
      end else begin
        unique case (pwc_q)
          rtcap_pkg::RTCAP_S_IDLE: begin
            if (alarm_evt && stab_q != 8'h00) begin
              pwc_q <= rtcap_pkg::RTCAP_S_STAB;
              cnt_q <= stab_q;
            end else if (alarm_evt && samp_q != 8'h00) begin
              pwc_q <= rtcap_pkg::RTCAP_S_SAMP;
              cnt_q <= samp_q;
            end
          end
          rtcap_pkg::RTCAP_S_STAB: begin
            if (ticks.pwc && cnt_q == 8'h01) begin
              if (samp_q != 8'h00) begin
                pwc_q <= rtcap_pkg::RTCAP_S_SAMP;
                cnt_q <= samp_q;
              end else begin
                pwc_q <= rtcap_pkg::RTCAP_S_IDLE;
              end
            end else if (ticks.pwc) begin
              cnt_q <= 8'(cnt_q - 8'h01);
            end
          end
          rtcap_pkg::RTCAP_S_SAMP: begin
            if (ticks.pwc && cnt_q == 8'h01) begin
              pwc_q <= rtcap_pkg::RTCAP_S_IDLE;
            end else if (ticks.pwc) begin
              cnt_q <= 8'(cnt_q - 8'h01);
            end
          end
          default: pwc_q <= rtcap_pkg::RTCAP_S_IDLE; // Illegal code recovers
        endcase
      end
    end
  end

  // Power is on in both windows; FFh holds the sample window open
  assign pwc_power_on   = (pwc_q != rtcap_pkg::RTCAP_S_IDLE);
  assign pwc_sample_win = (pwc_q == rtcap_pkg::RTCAP_S_SAMP) |
                          (samp_q == `RTCAP_SAMP_ALWAYS);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Locked weekday/hour write leaves the fields alone
  lock_wdhr_a: assert property (
    wr_en && wsel == rtcap_pkg::RTCAP_R_WDHR && !unlock_q
    |=> $stable({al_alarm_weekday_digit_q, al_hr_t_q, al_hr_o_q}))
    else $error("locked weekday/hour write took effect");

  // Unused weekday/hour bits read as zero
  unused_zero_a: assert property (
    ce && rd_wait_q && rsel == rtcap_pkg::RTCAP_R_WDHR
    |=> hrdata[31:11] == 21'h0 && hrdata[7:6] == 2'h0 && hrdata[10:8] == al_alarm_weekday_digit_q)
    else $error("weekday/hour readback wrong");

  // Final alarm turns the alarm off
  last_alarm_a: assert property (
    alarm_evt && !alcfg_wr && rpt_q == 8'h00 && !chime_q |=> !al_en_q)
    else $error("alarm enable not cleared after last alarm");

  // Repeat count steps down by one per alarm
  repeat_dec_a: assert property (
    alarm_evt && !alcfg_wr && rpt_q != 8'h00
    |=> rpt_q == 8'($past(rpt_q) - 8'h01) && al_en_q)
    else $error("repeat count did not decrement");

  // Chime rolls over and keeps the alarm on
  chime_roll_a: assert property (
    alarm_evt && !alcfg_wr && rpt_q == 8'h00 && chime_q |=> rpt_q == 8'hFF && al_en_q)
    else $error("chime rollover missing");

  // Interrupt and toggle follow each alarm
  irq_toggle_a: assert property (
    alarm_evt |=> alarm_irq && alarm_pulse != $past(alarm_pulse))
    else $error("alarm interrupt or pulse missing");

  // Reserved masks never raise alarms
  reserved_mask_a: assert property (
    mask_q > `RTCAP_MSK_YEAR |-> !alarm_evt)
    else $error("reserved mask produced alarm");

  // Window pointer steps toward zero
  ptr_dec_a: assert property (
    ce && rd_wait_q && decode(rd_addr_q) == rtcap_pkg::RTCAP_R_WIN && ptr_q != 2'h0
    |=> ptr_q == 2'($past(ptr_q) - 2'h1))
    else $error("window pointer did not decrement");

  // Alarm starts the stability window with its count
  stab_start_a: assert property (
    pwc_q == rtcap_pkg::RTCAP_S_IDLE && pwc_en_q && alarm_evt && stab_q != 8'h00
    |=> pwc_q == rtcap_pkg::RTCAP_S_STAB && cnt_q == $past(stab_q) && pwc_power_on)
    else $error("stability window not started");

  // Sample window forced open by FFh
  samp_always_a: assert property (
    samp_q == 8'hFF |-> pwc_sample_win)
    else $error("sample window not held open");

  // Quarter-minute correction carries the calibration value
  cal_quarter_a: assert property (
    quarter |=> cal_adjust.valid && cal_adjust.delta == $past(cal_q))
    else $error("calibration correction missing");

endmodule // rtcap_top

// ===== verif/rtcap_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module rtcap_top_tb;
  logic                   clk_sys         = 1'b0;  // 25 MHz system clock
  logic                   rstn            = 1'b0;  // Synchronous reset, active low
  logic                   ce              = 1'b1;  // Clock enable, held high except during t_hold
  logic                   hsel            = 1'b0;  // Slave select
  logic [31:0]            haddr           = '0;    // Byte address
  logic [1:0]             htrans          = 2'b00; // Transfer type
  logic                   hwrite          = 1'b0;  // Write strobe
  logic [31:0]            hwdata          = '0;    // Write data
  logic                   hready;                  // Single slave, so hreadyout is hready
  logic                   hresp;                   // Response, always OKAY
  logic [31:0]            hrdata;                  // Read data
  rtcap_pkg::rtcap_time_t cur_time        = '0;    // Current clock digits
  rtcap_pkg::rtcap_tick_t ticks           = '0;    // Timebase strobes
  logic                   clock_sync_flag = 1'b0;  // Sync flag shown to software
  logic                   alarm_irq;               // Alarm interrupt pulse
  logic                   alarm_pulse;             // Half-rate alarm output
  logic                   pwc_power_on;            // Power window active
  logic                   pwc_sample_win;          // Sample window active
  rtcap_pkg::rtcap_cal_t  cal_adjust;              // Prescaler correction
  int                     num_errors      = 0;     // Mismatches seen
  int                     check_count     = 0;     // Comparisons made
  int                     cycles          = 0;     // Hang guard
  rtcap_top dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cur_time(cur_time),
    .ticks(ticks), .clock_sync_flag(clock_sync_flag), .alarm_irq(alarm_irq),
    .alarm_pulse(alarm_pulse), .pwc_power_on(pwc_power_on),
    .pwc_sample_win(pwc_sample_win), .cal_adjust(cal_adjust));
  // Free-running clock, 40 ns period
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hung handshake short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // One single transfer; ready is read at the falling edge so the rising edge never races
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    logic rdy;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do begin
      @(negedge clk_sys);
      rdy = hready;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge clk_sys);
      rdy = hready;
      r   = hrdata;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  // Register read with comparison
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(r, e)
    `CHK(hresp, 1'b0)
  endtask
  // One-cycle strobe; returns at the falling edge after the design has seen it
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    ticks <= rtcap_pkg::rtcap_tick_t'(ticks | m);
    @(posedge clk_sys);
    ticks <= rtcap_pkg::rtcap_tick_t'(ticks & ~m);
    @(negedge clk_sys);
  endtask
  // Locked writes, field masks and the live sync flag
  task automatic t_regs();
    rd(8'h20, 32'h0);
    wr(8'h00, 32'hFFFF);
    rd(8'h00, 32'h0);
    wr(8'h08, 32'hFFFF);
    rd(8'h08, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h7F7F);
    clock_sync_flag <= 1'b1;
    wr(8'h10, 32'h2000);
    rd(8'h10, 32'h3000);
    clock_sync_flag <= 1'b0;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h073F);
  endtask
  // Window pointer walks 3, 2, 1, 0 and then stays
  task automatic t_window();
    logic [31:0] e [5] = '{32'h1234, 32'h0, 32'h0512, 32'h3456, 32'h3456};
    wr(8'h08, 32'h1234);
    wr(8'h00, 32'h0512);
    wr(8'h04, 32'h3456);
    wr(8'h0C, 32'h0300);
    for (int i = 0; i < 5; i++) begin
      rd(8'h14, e[i]);
    end
    rd(8'h0C, 32'h0);
  endtask
  // Repeat count one: two alarms, then enable drops
  task automatic t_repeat();
    wr(8'h0C, 32'h8401);
    pulse(4'hC);
    `CHK({alarm_irq, alarm_pulse}, 2'b11)
    rd(8'h0C, 32'h8400);
    pulse(4'hC);
    `CHK(alarm_irq, 1'b1)
    rd(8'h0C, 32'h0400);
    pulse(4'hC);
    `CHK({alarm_irq, alarm_pulse}, 2'b00)
    wr(8'h0C, 32'hC400);
    pulse(4'hC);
    rd(8'h0C, 32'hC4FF);
  endtask
  // Every mask code against a matching clock, then a digit mismatch
  task automatic t_masks();
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    cur_time.mday_first <= 1'b1;
    cur_time.mon_first  <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(8'h0C, 32'h8000 | 32'(c << 10));
      pulse(4'hC);
      `CHK(alarm_irq, 1'(c < 10))
    end
    cur_time.sec_o <= 4'h1;
    wr(8'h0C, 32'h8800);
    pulse(4'hC);
    `CHK(alarm_irq, 1'b0)
    cur_time.sec_o <= 4'h0;
  endtask
  // Stability then sample window in power-control periods
  task automatic t_power();
    wr(8'h10, 32'hA000);
    wr(8'h08, 32'h0201);
    wr(8'h0C, 32'hC400);
    pulse(4'hC);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b10)
    pulse(4'h2);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b10)
    pulse(4'h2);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b11)
    pulse(4'h2);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b00)
    wr(8'h08, 32'h0001);
    pulse(4'hC);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b11)
    pulse(4'h2);
    wr(8'h08, 32'h0000);
    pulse(4'hC);
    `CHK({pwc_power_on, pwc_sample_win}, 2'b00)
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h2000);
    wr(8'h08, 32'h00FF);
    @(negedge clk_sys);
    `CHK(pwc_sample_win, 1'b1)
    wr(8'h08, 32'h0);
  endtask
  // Correction only on the quarter-minute seconds
  task automatic t_calib();
    wr(8'h10, 32'h20FE);
    ticks.timer_on <= 1'b1;
    cur_time.sec_t <= 3'h1;
    cur_time.sec_o <= 4'h5;
    pulse(4'hC);
    `CHK(cal_adjust, {1'b1, 8'hFE})
    cur_time.sec_o <= 4'h6;
    pulse(4'hC);
    `CHK(cal_adjust.valid, 1'b0)
    wr(8'h10, 32'h2003);
    cur_time.sec_t <= 3'h3;
    cur_time.sec_o <= 4'h0;
    pulse(4'hC);
    `CHK(cal_adjust, {1'b1, 8'h03})
  endtask
  // Clock enable low freezes the alarm logic, so a matching second is missed
  task automatic t_hold();
    wr(8'h0C, 32'h8400);
    ce <= 1'b0;
    pulse(4'hC);
    `CHK(alarm_irq, 1'b0)
    ce <= 1'b1;
    rd(8'h0C, 32'h8400);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_window();
    t_repeat();
    t_masks();
    t_power();
    t_calib();
    t_hold();
    test_done();
  end
endmodule // rtcap_top_tb
